/* bench/host_model.sv */
`timescale 1ns/10ps
// Host side: holds the update strobe low while asked
module host_model (
	input wire logic clk,
	input wire logic req,
	output logic strobe_n
);
	initial strobe_n = 1'b1;
	// Strobe level set on the falling edge
	always @(negedge clk) begin
		strobe_n <= !req;
	end
endmodule : host_model

/* bench/relay_logic_monitor.sv */
`timescale 1ns/10ps
module relay_logic_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] resistance_range_code,
	input wire logic resistance_function_select_n,
	input wire logic current_function_select_n,
	input wire logic ohms_zero_select,
	input wire logic output_off,
	input wire logic watchdog_alarm,
	input wire logic [7:0] range_select,
	input wire logic low_range_connect_relay,
	input wire logic zero_short_relay,
	input wire logic current_out_relay_a,
	input wire logic resistor_out_relay_a,
	input wire logic dc_current_ref_relay,
	input wire logic ac_current_drive_relay,
	input wire logic watchdog_alarm_late,
	input wire logic assembly_present_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------
	// Relay checks
	// ----------------
	chk_range_decode: assert property (
		!$past(reset) && !$past(resistance_function_select_n) |->
		range_select == ($past(ohms_zero_select) ? 8'h00 :
		8'h01 << $past(resistance_range_code))) else $error("range bad");
	chk_range_onehot: assert property (
		$onehot0(range_select)) else $error("range not one-hot");
	chk_connect_close: assert property (
		!$past(reset) && !watchdog_alarm_late |-> low_range_connect_relay ==
		($past(resistance_function_select_n) || !$past(resistance_range_code[2])
		|| $past(ohms_zero_select) || $past(resistance_range_code) == 3'h4))
		else $error("connect bad");
	chk_zero_short: assert property (
		!$past(reset) && !watchdog_alarm_late |-> zero_short_relay ==
		($past(resistance_function_select_n) || $past(ohms_zero_select)))
		else $error("zero short bad");
	chk_resistor_gate: assert property (
		resistor_out_relay_a |-> !$past(watchdog_alarm, 3) &&
		!$past(output_off) && !$past(resistance_function_select_n))
		else $error("resistor relay bad");
	chk_current_out: assert property (
		!$past(reset) && !watchdog_alarm_late |-> current_out_relay_a ==
		(!$past(current_function_select_n) && !$past(output_off)))
		else $error("current relay bad");
	chk_drive_alarm: assert property (
		dc_current_ref_relay || ac_current_drive_relay |->
		!$past(watchdog_alarm, 3)) else $error("drive relay bad");
	chk_present_low: assert property (
		!assembly_present_n) else $error("presence bad");
	chk_alarm_abort: assert property (
		$rose(watchdog_alarm_late) |-> $past(watchdog_alarm, 3))
		else $error("late alarm bad");
endmodule : relay_logic_monitor
bind ohms_range_default_relay_logic relay_logic_monitor mon (.*);

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic clk = 0, reset = 1, req = 0, host_update_strobe_n, watchdog_alarm = 0;
	logic [2:0] resistance_range_code = 0;
	logic resistance_function_select_n = 1, current_function_select_n = 1;
	logic dc_current_select = 0, ohms_zero_select = 0, output_off = 0;
	logic current_hf_filter_select = 0, dc_line_connect_select = 0;
	logic [7:0] range_select, lfsr = 8'h60, a;
	logic low_range_connect_relay, zero_short_relay, hf_filter_relay;
	logic dc_line_connect_relay, current_out_relay_a, current_out_relay_b;
	logic resistor_out_relay_a, resistor_out_relay_b, dc_current_ref_relay;
	logic ac_current_drive_relay, watchdog_alarm_late, latch_outputs_tristate;
	logic relay_update_strobe_n, assembly_present_n;
	logic [22:0] notes[$], n;
	int mismatches = 0, cmp_count = 0;
	ohms_range_default_relay_logic DUT (.*);
	host_model host (.clk(clk), .req(req), .strobe_n(host_update_strobe_n));
	always #5 clk = ~clk;
	function logic [7:0] step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : step
	// Expected outputs from the present inputs
	function logic [22:0] expect_of();
		logic f, c, k;
		f = !resistance_function_select_n;
		c = !current_function_select_n;
		k = ohms_zero_select;
		return {f, k ? 8'h00 : 8'h01 << resistance_range_code,
			!f | !resistance_range_code[2] | k | resistance_range_code == 3'h4,
			!f | k, {2{f & !output_off & !watchdog_alarm}},
			{2{c & !output_off}}, c & !watchdog_alarm & dc_current_select,
			c & !watchdog_alarm & !dc_current_select, 1'b0,
			host_update_strobe_n, 2'h0, current_hf_filter_select,
			dc_line_connect_select};
	endfunction : expect_of
	task check(input string name, input logic [13:0] s, e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, e, s);
		end
	endtask : check
	task end_sim();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Drive one step, hold through the alarm sync, then note the result
	task apply(input logic [7:0] x, y);
		@(negedge clk);
		{output_off, ohms_zero_select, dc_current_select} = x[7:5];
		current_function_select_n = !x[3] | x[4];
		{resistance_function_select_n, resistance_range_code} = x[3:0];
		{current_hf_filter_select, dc_line_connect_select, req} = y[2:0];
		watchdog_alarm = y[3] & y[4];
		repeat (3) @(negedge clk);
		notes.push_back(expect_of());
	endtask : apply
	// Watcher: oldest note against settled outputs
	always @(posedge clk) begin
		#1;
		if (notes.size() > 0) begin
			n = notes.pop_front();
			check("relays", {low_range_connect_relay, zero_short_relay,
				resistor_out_relay_a, resistor_out_relay_b, current_out_relay_a,
				current_out_relay_b, dc_current_ref_relay, ac_current_drive_relay,
				assembly_present_n, relay_update_strobe_n, watchdog_alarm_late,
				latch_outputs_tristate, hf_filter_relay, dc_line_connect_relay},
				n[13:0]);
			if (n[22])
				check("range", {6'h00, range_select}, {6'h00, n[21:14]});
		end
	end
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	// Reset, full code sweep with and without zero, then random steps
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) reset = 0;
		for (int i = 0; i < 16; i++)
			apply({1'b0, i[3], 2'h1, 1'b0, i[2:0]}, 8'h00);
		repeat (400) begin
			lfsr = step(lfsr);
			a = lfsr;
			lfsr = step(lfsr);
			apply(a, lfsr);
		end
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule : testbench

/* core/ohms_range_default_relay_logic.sv */
`timescale 1ns/10ps
`include "relay_logic_map.svh"

// Notes on behaviour
// [RULE1] Three-bit range code picks exactly one of eight range relays, 000 lowest.
// [RULE2] A range relay is selected when its select is logic-1, else deselected.
// [RULE3] Low-range connect relay engages only while no megohm range is active.
// [RULE4] Low-range connect drive is reversed: closes when its NOR output is 0.
// [RULE5] Connect closes when ohms off, top code bit 0, zero on, or 100k.
// [RULE6] Zero-short relay on for ohms with zero, or whenever ohms is off.
// [RULE7] Output-off opens current relays for current, resistor relays for ohms.
// [RULE8] Alarm opens DC reference, AC drive, or resistor relays per function.
// [RULE9] After 47 ms of alarm the delayed alarm tristates all latch outputs.
// [RULE10] Delayed alarm also holds the update strobe low for 1.5 seconds.
// [RULE11] Default state activates only HF filter, zero-short, connect, DC-line.
// [RULE12] Presence status line stays at logic-0 while the assembly is fitted.
// [RULE13] Host transfers data then pulses update strobe low for 50 ms.
// [RULE14] Resistor relays energise only for ohms, output on, no alarm.
// [RULE15] Ohms zero deselects all eight range relays whatever the code.
// [RULE16] Alarm dropping before 47 ms aborts the delayed default.
module ohms_range_default_relay_logic (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] resistance_range_code,
	input wire logic resistance_function_select_n,
	input wire logic current_function_select_n,
	input wire logic dc_current_select,
	input wire logic ohms_zero_select,
	input wire logic output_off,
	input wire logic current_hf_filter_select,
	input wire logic dc_line_connect_select,
	input wire logic host_update_strobe_n,
	input wire logic watchdog_alarm,
	output logic [7:0] range_select,
	output logic low_range_connect_relay,
	output logic zero_short_relay,
	output logic hf_filter_relay,
	output logic dc_line_connect_relay,
	output logic current_out_relay_a,
	output logic current_out_relay_b,
	output logic resistor_out_relay_a,
	output logic resistor_out_relay_b,
	output logic dc_current_ref_relay,
	output logic ac_current_drive_relay,
	output logic watchdog_alarm_late,
	output logic latch_outputs_tristate,
	output logic relay_update_strobe_n,
	output logic assembly_present_n
);
	import relay_logic_pkg::*;

	// ----------------------------------------
	// Timing constants
	// ----------------------------------------
	localparam logic [27:0] delay_cycles =
		28'(`ALARM_DELAY_CYCLES);
	localparam logic [27:0] strobe_cycles =
		28'(`DEFAULT_STROBE_CYCLES);

	// ----------------------------------------
	// State
	// ----------------------------------------
	relay_state_t state;
	relay_state_t next_state;
	logic [7:0] decoded;
	logic ohms_sel;
	logic current_sel;
	logic nor_out;
	logic dflt;
	logic alarm;

	// Decode one-hot ranges, one bit per code
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_range_one_hot_decoder
			assign decoded[g] = (resistance_range_code == 3'(g)); // RULE1
		end
	endgenerate

	// Next-state logic
	always_comb begin
		next_state = state;
		// Alarm synchroniser, two flops before use; only the second is read
		next_state.alarm_meta = {state.alarm_meta[0], watchdog_alarm};
		alarm = state.alarm_meta[1];
		dflt = (state.phase != phase_normal) &&
			(state.phase != phase_waiting);
		// Latches tristated: pull-ups give inactive functions, no zero
		ohms_sel = !resistance_function_select_n && !dflt;
		current_sel = !current_function_select_n && !dflt;

		// Delayed alarm sequencing
		unique case (state.phase)
			phase_normal: begin
				next_state.timer = '0;
				if (alarm) begin
					next_state.phase = phase_waiting;
				end
			end
			phase_waiting: begin
				if (!alarm) begin
					next_state.phase = phase_normal; // RULE16
					next_state.timer = '0;
				end else if (state.timer >= delay_cycles - 28'h1) begin
					next_state.phase = phase_forcing; // RULE9
					next_state.timer = '0;
				end else begin
					next_state.timer = state.timer + 28'h1;
				end
			end
			phase_forcing: begin
				if (state.timer >= strobe_cycles - 28'h1) begin
					next_state.phase = phase_holding; // RULE10
					next_state.timer = '0;
				end else begin
					next_state.timer = state.timer + 28'h1;
				end
			end
			phase_holding: begin
				next_state.timer = '0;
				if (!alarm) begin
					next_state.phase = phase_normal;
				end
			end
		endcase

		// Range selects, logic-1 selects, all off in zero or default
		if (ohms_zero_select || dflt) begin
			next_state.range_select = 8'h00; // RULE15
		end else begin
			next_state.range_select = decoded; // RULE2
		end

		// Low-range connect: NOR of closing terms, closes on NOR low
		nor_out = !(resistance_function_select_n || dflt ||
			!resistance_range_code[2] || ohms_zero_select ||
			(resistance_range_code == `RANGE_100K)); // RULE5
		next_state.low_range_connect_relay = !nor_out; // RULE3 RULE4

		// Zero-short relay
		next_state.zero_short_relay = !ohms_sel ||
			(ohms_sel && ohms_zero_select) || dflt; // RULE6

		// Output relays: current gated by off, drive by alarm, resistor by both
		next_state.current_out_relay_a = current_sel && !output_off; // RULE7
		next_state.current_out_relay_b = current_sel && !output_off; // RULE7
		next_state.resistor_out_relay_a =
			ohms_sel && !output_off && !alarm; // RULE14 RULE8
		next_state.resistor_out_relay_b =
			ohms_sel && !output_off && !alarm; // RULE14 RULE8
		next_state.dc_current_ref_relay =
			current_sel && !alarm && dc_current_select; // RULE8
		next_state.ac_current_drive_relay =
			current_sel && !alarm && !dc_current_select; // RULE8

		// Default state relays
		next_state.hf_filter_relay = dflt || current_hf_filter_select; // RULE11
		next_state.dc_line_connect_relay =
			dflt || dc_line_connect_select; // RULE11

		// Delayed alarm and strobe
		next_state.watchdog_alarm_late = dflt;
		next_state.latch_outputs_tristate = dflt; // RULE9
		next_state.relay_update_strobe_n = (state.phase == phase_forcing) ?
			1'b0 : host_update_strobe_n; // RULE10 RULE13
		next_state.assembly_present_n = 1'b0; // RULE12
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
			state.phase <= phase_normal;
			state.relay_update_strobe_n <= 1'b1;
			state.zero_short_relay <= 1'b1;
			state.low_range_connect_relay <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flops
	assign range_select = state.range_select;
	assign low_range_connect_relay = state.low_range_connect_relay;
	assign zero_short_relay = state.zero_short_relay;
	assign hf_filter_relay = state.hf_filter_relay;
	assign dc_line_connect_relay = state.dc_line_connect_relay;
	assign current_out_relay_a = state.current_out_relay_a;
	assign current_out_relay_b = state.current_out_relay_b;
	assign resistor_out_relay_a = state.resistor_out_relay_a;
	assign resistor_out_relay_b = state.resistor_out_relay_b;
	assign dc_current_ref_relay = state.dc_current_ref_relay;
	assign ac_current_drive_relay = state.ac_current_drive_relay;
	assign watchdog_alarm_late = state.watchdog_alarm_late;
	assign latch_outputs_tristate = state.latch_outputs_tristate;
	assign relay_update_strobe_n = state.relay_update_strobe_n;
	assign assembly_present_n = state.assembly_present_n;

endmodule : ohms_range_default_relay_logic

/* shared/relay_logic_map.svh */
`ifndef RELAY_LOGIC_MAP_SVH
`define RELAY_LOGIC_MAP_SVH

// Clock period in nanoseconds
`define CLK_PERIOD_NS 10
// Delay from alarm to default, in ms
`define ALARM_DELAY_MS 47
// Length of forced update strobe, in ms
`define DEFAULT_STROBE_MS 1500
// Cycle counts derived from the times
`define ALARM_DELAY_CYCLES ((`ALARM_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define DEFAULT_STROBE_CYCLES ((`DEFAULT_STROBE_MS * 1000000) / `CLK_PERIOD_NS)
// Range code of the 100k ohm range
`define RANGE_100K 3'h4
// Width of the timing counter
`define TIMER_WIDTH 28

`endif

/* shared/relay_logic_pkg.sv */
package relay_logic_pkg;

	// Watchdog default sequencing phases
	typedef enum logic [1:0] {
		phase_normal,
		phase_waiting,
		phase_forcing,
		phase_holding
	} alarm_phase_t;

	// Complete state of the block
	typedef struct packed {
		logic [1:0] alarm_meta;
		alarm_phase_t phase;
		logic [27:0] timer;
		logic [7:0] range_select;
		logic low_range_connect_relay;
		logic zero_short_relay;
		logic hf_filter_relay;
		logic dc_line_connect_relay;
		logic current_out_relay_a;
		logic current_out_relay_b;
		logic resistor_out_relay_a;
		logic resistor_out_relay_b;
		logic dc_current_ref_relay;
		logic ac_current_drive_relay;
		logic watchdog_alarm_late;
		logic latch_outputs_tristate;
		logic relay_update_strobe_n;
		logic assembly_present_n;
	} relay_state_t;

endpackage : relay_logic_pkg
